// ### src/acccr_regs.sv
// Channel two/three calibration and channel three setup registers
//
// Operation
// - Ch2 offset: upper bits 23:8, low byte 15:8
// - Lower calibration bits 7:0 read zero
// - Ch2 gain split alike, upper resets 8000h
// - Ch3 signed delay in setup bits 15:6
// - Setup bits 5:3 reserved, read zero
// - Setup bit 2 disables ch3 high-pass
// - Setup bits 1:0 pick ch3 input
// - Ch3 offset at 19h/1Ah, reset zero
// - Ch3 gain low byte at 1Ch
`timescale 1ns/100ps
module acccr_regs (
  // Clock, reset, enable
  input  wire logic        clk_i,                    // System clock
  input  wire logic        rst_i,                    // Sync reset, high
  input  wire logic        ce_i,                     // Freezes all state except ack
  // Classic Wishbone slave
  input  wire logic        wb_cyc_i,                 // Bus cycle
  input  wire logic        wb_stb_i,                 // Strobe
  input  wire logic        wb_we_i,                  // Write enable
  input  wire logic [7:0]  wb_adr_i,                 // Byte address
  input  wire logic [3:0]  wb_sel_i,                 // Byte enables
  input  wire logic [31:0] wb_dat_i,                 // Write data
  output logic      [31:0] wb_dat_o,                 // Read data
  output logic             wb_ack_o,                 // Acknowledge
  // Shared high-pass control from the global filter logic
  input  wire logic        global_highpass_setting_i, // Global enable
  // Calibration words for the datapath
  output logic      [23:0] ch2_offset_word_o,        // Ch2 offset
  output logic      [23:0] ch2_gain_word_o,          // Ch2 gain
  output logic      [23:0] ch3_offset_word_o,        // Ch3 offset
  output logic      [23:0] ch3_gain_word_o,          // Ch3 gain
  // Channel three setup
  output logic      [9:0]  ch3_delay_cycles_o,       // Signed delay
  output logic             ch3_highpass_off_o,       // Local disable
  output logic             ch3_highpass_en_o,        // Effective filter
  output logic      [1:0]  ch3_input_select_o        // Input routing
);

  // Local shorthands for the setup field positions
  localparam int unsigned DMSB = acccr_pkg::DELAY_MSB;
  localparam int unsigned DLSB = acccr_pkg::DELAY_LSB;
  localparam int unsigned SMSB = acccr_pkg::INSEL_MSB;
  localparam int unsigned SLSB = acccr_pkg::INSEL_LSB;
  localparam int unsigned HPB  = acccr_pkg::HP_OFF_BIT;
  localparam int unsigned NCAL = acccr_pkg::NUM_CAL;

  // All state of the top level in one record
  typedef struct packed {
    logic                       ack;       // Bus acknowledge
    logic [15:0]                rdata;     // Captured read data
    logic [9:0]                 delay;     // Ch3 phase delay count
    logic                       hp_off;    // Ch3 high-pass disable
    acccr_pkg::acccr_insel_t    insel;     // Ch3 input selection
    logic                       hp_en;     // Effective filter enable
  } acccr_top_state_t;

  acccr_top_state_t q;  // Registered state
  acccr_top_state_t d;  // Next state

  // Bus decode
  logic [5:0]       idx;       // Register index from byte address
  logic             req;       // New request this cycle
  logic             wr_en;     // Write accepted this cycle
  logic [15:0]      wdata;     // Low half of write data
  logic [1:0]       be;        // Low two byte enables
  logic [15:0]      setup_img; // Setup register as read back

  // Per-word strobes and read images
  logic [NCAL-1:0]  wr_high;   // Upper register write strobes
  logic [NCAL-1:0]  wr_low;    // Lower register write strobes
  logic [15:0]      high_img [NCAL];  // Upper register images
  logic [15:0]      low_img  [NCAL];  // Lower register images
  logic [23:0]      cal_word [NCAL];  // Combined words

  // Index, not byte address, selects the register; bits 1:0 ignored
  assign idx   = wb_adr_i[7:2];
  // Only the first cycle of a request with ce_i high is taken; the ack cycle blocks it
  assign req   = wb_cyc_i && wb_stb_i && !q.ack;
  assign wr_en = req && wb_we_i;
  // Registers are 16 bits wide, so only lanes 0 and 1 carry data
  assign wdata = wb_dat_i[15:0];
  assign be    = wb_sel_i[1:0];

  // Setup register image; bits 5:3 are tied low
  always_comb begin
    setup_img                  = 16'h0000;
    setup_img[DMSB:DLSB]       = q.delay;
    setup_img[HPB]             = q.hp_off;
    setup_img[SMSB:SLSB]       = q.insel;
  end

  // One calibration word per entry: ch2 offset/gain, ch3 offset/gain
  for (genvar k = 0; k < NCAL; k++) begin : g_cal
    // Strobes decoded from the fixed index pair of this word
    assign wr_high[k] = wr_en && (idx == acccr_pkg::CAL_HIGH_IDX[k]);
    assign wr_low[k]  = wr_en && (idx == acccr_pkg::CAL_LOW_IDX[k]);

    // Reset of the upper half differs between offset and gain
    acccr_cal_word #(
      .HIGH_RESET (acccr_pkg::CAL_HIGH_RESET[k])
    ) u_word (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .ce_i       (ce_i),
      .wr_high_i  (wr_high[k]),
      .wr_low_i   (wr_low[k]),
      .be_i       (be),
      .wdata_i    (wdata),
      .high_o     (high_img[k]),
      .low_o      (low_img[k]),
      .word_o     (cal_word[k])
    );
  end

  // Next state: bus handshake, setup writes, read capture
  always_comb begin
    d = q;
    // Ack is a single-cycle pulse; it drops in the cycle after
    d.ack = req;

    // Setup writes; lane zero also holds the reserved bits, which are not stored
    if (wr_en && (idx == acccr_pkg::CH3_CHANNEL_SETUP_IDX)) begin
      if (be[0]) begin
        d.hp_off = wdata[HPB];
        d.insel  = acccr_pkg::acccr_insel_t'(wdata[SMSB:SLSB]);
        d.delay[1:0] = wdata[7:6];
      end
      if (be[1]) begin
        d.delay[9:2] = wdata[15:8];
      end
      // Bits 5:3 have no storage, so written ones are dropped
    end

    // Filter runs only when global setting allows and not disabled
    d.hp_en = global_highpass_setting_i && !d.hp_off;

    // Read data is captured with the request; unmapped reads give zero
    if (req && !wb_we_i) begin
      d.rdata = 16'h0000;
      if (idx == acccr_pkg::CH3_CHANNEL_SETUP_IDX) begin
        d.rdata = setup_img;
      end
      for (int i = 0; i < NCAL; i++) begin
        if (idx == acccr_pkg::CAL_HIGH_IDX[i]) begin
          d.rdata = high_img[i];
        end
        if (idx == acccr_pkg::CAL_LOW_IDX[i]) begin
          d.rdata = low_img[i];
        end
      end
    end
  end

  // State register; reset acts even while the enable is low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q.ack    <= 1'b0;
      q.rdata  <= 16'h0000;
      q.delay  <= acccr_pkg::DELAY_RESET;
      q.hp_off <= acccr_pkg::SETUP_RESET[HPB];
      q.insel  <= acccr_pkg::ACCCR_IN_OWN_PAIR;
      q.hp_en  <= 1'b0;
    end else if (ce_i) begin
      q <= d;
    end else begin
      // Ack is the one bit not frozen: a held ack would answer the
      // master's next request before that request was ever taken
      q.ack <= 1'b0;
    end
  end

  // Bus outputs; upper half of the data bus always reads zero
  assign wb_ack_o = q.ack;
  assign wb_dat_o = {16'h0000, q.rdata};

  // Datapath words, taken from the word flops
  assign ch2_offset_word_o = cal_word[0];
  assign ch2_gain_word_o   = cal_word[1];
  assign ch3_offset_word_o = cal_word[2];
  assign ch3_gain_word_o   = cal_word[3];

  // Setup outputs
  assign ch3_delay_cycles_o = q.delay;
  assign ch3_highpass_off_o = q.hp_off;
  assign ch3_highpass_en_o  = q.hp_en;
  assign ch3_input_select_o = q.insel;

endmodule // acccr_regs

// ### src/acccr_pkg.sv
// Constants and types shared by the channel calibration register slice
package acccr_pkg;

  // Bus geometry: one register per aligned 32-bit word
  localparam int unsigned ADDR_W = 8;   // Byte address width
  localparam int unsigned IDX_W  = 6;   // Register index width
  localparam int unsigned DATA_W = 32;  // Bus data width
  localparam int unsigned REG_W  = 16;  // Register width
  localparam int unsigned SEL_W  = 4;   // Byte enables

  // Register indices; byte address is four times the index
  localparam logic [5:0] CH2_OFFSET_CORR_HIGH_IDX = 6'h14;
  localparam logic [5:0] CH2_OFFSET_CORR_LOW_IDX  = 6'h15;
  localparam logic [5:0] CH2_GAIN_CORR_HIGH_IDX   = 6'h16;
  localparam logic [5:0] CH2_GAIN_CORR_LOW_IDX    = 6'h17;
  localparam logic [5:0] CH3_CHANNEL_SETUP_IDX    = 6'h18;
  localparam logic [5:0] CH3_OFFSET_CORR_HIGH_IDX = 6'h19;
  localparam logic [5:0] CH3_OFFSET_CORR_LOW_IDX  = 6'h1a;
  localparam logic [5:0] CH3_GAIN_CORR_HIGH_IDX   = 6'h1b;
  localparam logic [5:0] CH3_GAIN_CORR_LOW_IDX    = 6'h1c;

  // Calibration words, in the order ch2 offset, ch2 gain, ch3 offset, ch3 gain
  localparam int unsigned NUM_CAL = 4;
  localparam logic [5:0] CAL_HIGH_IDX [NUM_CAL] = '{
    CH2_OFFSET_CORR_HIGH_IDX, CH2_GAIN_CORR_HIGH_IDX,
    CH3_OFFSET_CORR_HIGH_IDX, CH3_GAIN_CORR_HIGH_IDX};
  localparam logic [5:0] CAL_LOW_IDX [NUM_CAL] = '{
    CH2_OFFSET_CORR_LOW_IDX, CH2_GAIN_CORR_LOW_IDX,
    CH3_OFFSET_CORR_LOW_IDX, CH3_GAIN_CORR_LOW_IDX};

  // Reset values
  localparam logic [15:0] OFFSET_HIGH_RESET = 16'h0000;
  localparam logic [15:0] GAIN_HIGH_RESET   = 16'h8000;
  localparam logic [7:0]  LOW_BYTE_RESET    = 8'h00;
  localparam logic [15:0] SETUP_RESET       = 16'h0000;
  localparam logic [15:0] CAL_HIGH_RESET [NUM_CAL] = '{
    OFFSET_HIGH_RESET, GAIN_HIGH_RESET,
    OFFSET_HIGH_RESET, GAIN_HIGH_RESET};

  // Field positions
  localparam int unsigned LOW_BYTE_MSB = 15;  // Low calibration byte
  localparam int unsigned LOW_BYTE_LSB = 8;
  localparam int unsigned DELAY_MSB    = 15;  // Ch3 phase delay
  localparam int unsigned DELAY_LSB    = 6;
  localparam int unsigned DELAY_W      = 10;
  localparam int unsigned HP_OFF_BIT   = 2;   // Ch3 high-pass disable
  localparam int unsigned INSEL_MSB    = 1;   // Ch3 input select
  localparam int unsigned INSEL_LSB    = 0;

  // Channel three input selection encodings
  typedef enum logic [1:0] {
    ACCCR_IN_OWN_PAIR = 2'h0,  // Own positive/negative input pair
    ACCCR_IN_SHORTED  = 2'h1,  // Converter inputs shorted
    ACCCR_IN_TEST_POS = 2'h2,  // Positive DC test signal
    ACCCR_IN_TEST_NEG = 2'h3   // Negative DC test signal
  } acccr_insel_t;

  // Reset value of the delay field
  localparam logic [9:0] DELAY_RESET = 10'h000;

endpackage

// ### src/acccr_cal_word.sv
// One 24-bit calibration word held as an upper and a lower register
`timescale 1ns/100ps
module acccr_cal_word #(
  parameter logic [15:0] HIGH_RESET = 16'h0000  // Upper register reset
) (
  input  wire logic        clk_i,        // System clock
  input  wire logic        rst_i,        // Synchronous reset, high
  input  wire logic        ce_i,         // Clock enable
  input  wire logic        wr_high_i,    // Write strobe, upper register
  input  wire logic        wr_low_i,     // Write strobe, lower register
  input  wire logic [1:0]  be_i,         // Byte enables, low two lanes
  input  wire logic [15:0] wdata_i,      // Write data
  output logic      [15:0] high_o,       // Upper register image
  output logic      [15:0] low_o,        // Lower register image
  output logic      [23:0] word_o        // Combined word for the datapath
);

  // All state of this word
  typedef struct packed {
    logic [15:0] high;  // Word bits 23:8
    logic [7:0]  low;   // Word bits 7:0
  } acccr_cal_state_t;

  acccr_cal_state_t q;  // Registered state
  acccr_cal_state_t d;  // Next state

  // Byte-lane writes; the lower register has only its high lane
  always_comb begin
    d = q;
    if (wr_high_i && be_i[0]) begin
      d.high[7:0] = wdata_i[7:0];
    end
    if (wr_high_i && be_i[1]) begin
      d.high[15:8] = wdata_i[15:8];
    end
    // Lane zero is reserved and write data there is dropped
    if (wr_low_i && be_i[1]) begin
      d.low = wdata_i[acccr_pkg::LOW_BYTE_MSB:acccr_pkg::LOW_BYTE_LSB];
    end
  end

  // State register; reset wins over a frozen clock enable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q.high <= HIGH_RESET;
      q.low  <= acccr_pkg::LOW_BYTE_RESET;
    end else if (ce_i) begin
      q <= d;
    end
  end

  // Register images and the word, all straight from the flops
  assign high_o = q.high;
  assign low_o  = {q.low, 8'h00};
  assign word_o = {q.high, q.low};

endmodule // acccr_cal_word

// ### test/acccr_chk.sv
// Port assertions for the calibration register slice
`timescale 1ns/100ps
module acccr_chk (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic [23:0] ch2_offset_word_o,
  input wire logic [23:0] ch2_gain_word_o,
  input wire logic [23:0] ch3_offset_word_o,
  input wire logic [23:0] ch3_gain_word_o,
  input wire logic [9:0]  ch3_delay_cycles_o,
  input wire logic        ch3_highpass_off_o,
  input wire logic [1:0]  ch3_input_select_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Request stays held through its ack cycle
  logic       rd;   // Read answer now
  logic [5:0] ix;   // Register index
  assign rd = wb_ack_o && !wb_we_i;
  assign ix = wb_adr_i[7:2];
  chk_low_res_zero: assert property (
    rd && ix inside {6'h15, 6'h17, 6'h1a, 6'h1c} |-> wb_dat_o[7:0] == 8'h00)
    else $error("low reserved bits set");
  chk_setup_res_zero: assert property (
    rd && ix == 6'h18 |-> wb_dat_o[5:3] == 3'h0) else $error("setup gap");
  chk_setup_read: assert property (
    rd && ix == 6'h18 |-> wb_dat_o[15:0] == {ch3_delay_cycles_o, 3'h0,
    ch3_highpass_off_o, ch3_input_select_o}) else $error("setup read");
  chk_setup_write: assert property (
    wb_ack_o && wb_we_i && ix == 6'h18 && wb_sel_i[1:0] == 2'h3 |->
    {ch3_delay_cycles_o, ch3_highpass_off_o, ch3_input_select_o}
    == {wb_dat_i[15:6], wb_dat_i[2:0]}) else $error("setup write");
  chk_ch2_off_high: assert property (
    rd && ix == 6'h14 |-> wb_dat_o[15:0] == ch2_offset_word_o[23:8])
    else $error("ch2 offset upper");
  chk_ch2_off_low: assert property (
    rd && ix == 6'h15 |-> wb_dat_o[15:8] == ch2_offset_word_o[7:0])
    else $error("ch2 offset lower");
  chk_ch3_off_high: assert property (
    rd && ix == 6'h19 |-> wb_dat_o[15:0] == ch3_offset_word_o[23:8])
    else $error("ch3 offset upper");
  chk_ch3_gain_low: assert property (
    rd && ix == 6'h1c |-> wb_dat_o[15:8] == ch3_gain_word_o[7:0])
    else $error("ch3 gain lower");
  chk_reset_words: assert property (
    $fell(rst_i) |-> ch2_gain_word_o == 24'h800000 && ch3_gain_word_o ==
    24'h800000 && ch2_offset_word_o == 0 && ch3_offset_word_o == 0)
    else $error("reset words");
  // Ack is a single pulse, even when the enable stalls the slice
  chk_ack_single: assert property (
    wb_ack_o |=> !wb_ack_o) else $error("ack held");
  cover property (rd && ix == 6'h18);
  cover property (wb_ack_o && wb_we_i);
  cover property ($fell(rst_i));
endmodule // acccr_chk
bind acccr_regs acccr_chk acccr_chk_inst (.clk_i, .rst_i, .wb_we_i,
  .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .ch2_offset_word_o,
  .ch2_gain_word_o, .ch3_offset_word_o, .ch3_gain_word_o,
  .ch3_delay_cycles_o, .ch3_highpass_off_o, .ch3_input_select_o);

// ### test/acccr_host.sv
// Host model: classic Wishbone master
`timescale 1ns/100ps
module acccr_host (
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic [31:0] rdat_i,
  output logic             cyc_o,
  output logic             stb_o,
  output logic             we_o,
  output logic      [7:0]  adr_o,
  output logic      [3:0]  sel_o,
  output logic      [31:0] dat_o
);
  initial {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = '0;
  // One cycle; held until ack is sampled high
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [3:0] s, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk_i);
    {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} <= {2'h3, w, a, s, d};
    do @(posedge clk_i); while (ack_i !== 1'b1);
    r = rdat_i;
    // Released lines show no stale value
    {cyc_o, stb_o, adr_o, dat_o} <= {2'h0, ~a, ~d};
  endtask
endmodule // acccr_host

// ### test/tb.sv
// Self-checking bench for the calibration register slice
`timescale 1ns/100ps
module tb;
  logic        clk_i, rst_i, ce_i, global_highpass_setting_i;
  logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [23:0] ch2_offset_word_o, ch2_gain_word_o;
  logic [23:0] ch3_offset_word_o, ch3_gain_word_o;
  logic [9:0]  ch3_delay_cycles_o;
  logic        ch3_highpass_off_o, ch3_highpass_en_o;
  logic [1:0]  ch3_input_select_o;
  logic [15:0] m [64];       // Register model
  logic [15:0] lf, cf;       // Random state
  logic        rnd;          // Random stall phase
  int          num_errors, checked, cyc_n, i;
  acccr_regs acccr_regs_inst (.clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .global_highpass_setting_i, .ch2_offset_word_o, .ch2_gain_word_o,
    .ch3_offset_word_o, .ch3_gain_word_o, .ch3_delay_cycles_o,
    .ch3_highpass_off_o, .ch3_highpass_en_o, .ch3_input_select_o);
  acccr_host host_inst (.clk_i, .ack_i(wb_ack_o), .rdat_i(wb_dat_o),
    .cyc_o(wb_cyc_i), .stb_o(wb_stb_i), .we_o(wb_we_i), .adr_o(wb_adr_i),
    .sel_o(wb_sel_i), .dat_o(wb_dat_i));
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  function automatic logic [15:0] nxt(logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic chk(input logic [31:0] s, e, input string t);
    checked++;
    if (s !== e) begin
      num_errors++;
      $display("wrong value at %0t: %s", $time, t);
    end
  endtask
  task automatic results;
    $display("checked %0d, errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Datapath words and setup outputs against the model
  task automatic outs;
    chk(ch2_offset_word_o, {m[6'h14], m[6'h15][15:8]}, "o2");
    chk(ch2_gain_word_o, {m[6'h16], m[6'h17][15:8]}, "g2");
    chk(ch3_offset_word_o, {m[6'h19], m[6'h1a][15:8]}, "o3");
    chk(ch3_gain_word_o, {m[6'h1b], m[6'h1c][15:8]}, "g3");
    chk(ch3_delay_cycles_o, m[6'h18][15:6], "dly");
    chk(ch3_highpass_off_o, m[6'h18][2], "off");
    chk(ch3_input_select_o, m[6'h18][1:0], "sel");
  endtask
  task automatic wr(input logic [7:0] a, input logic [3:0] s,
    input logic [31:0] d);
    logic [31:0] r;
    logic [15:0] k;
    host_inst.xfer(1'b1, a, s, d, r);
    k = {{8{s[1]}}, {8{s[0]}}};
    case (a[7:2])
      6'h14, 6'h16, 6'h19, 6'h1b: k = k;
      6'h15, 6'h17, 6'h1a, 6'h1c: k &= 16'hff00;
      6'h18: k &= 16'hffc7;
      default: k = 16'h0000;
    endcase
    m[a[7:2]] = (m[a[7:2]] & ~k) | (d[15:0] & k);
    outs();
  endtask
  task automatic rd(input logic [7:0] a);
    logic [31:0] r;
    host_inst.xfer(1'b0, a, 4'hf, 32'h0, r);
    chk(r, {16'h0, m[a[7:2]]}, "read");
    outs();
  endtask
  // Reset image, then read every place and three unmapped
  task automatic sweep;
    foreach (m[j]) m[j] = 16'h0000;
    m[6'h16] = 16'h8000;
    m[6'h1b] = 16'h8000;
    for (int j = 6'h13; j <= 6'h1d; j++) rd({j[5:0], 2'h0});
    rd(8'h80);
  endtask
  // Hang guard and random bus stalls through ce_i
  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    cf <= nxt(cf);
    ce_i <= !rnd || cf[0] || cf[5];
    if (cyc_n == 20000) begin
      num_errors++;
      results();
    end
  end
  initial begin
    {rst_i, ce_i, rnd, global_highpass_setting_i} = 4'hc;
    {num_errors, checked, cyc_n} = '0;
    {lf, cf} = {16'h003c, 16'h003c};
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    sweep();
    $display("test reset done");
    // Each routing code, filter off and global setting
    for (i = 0; i < 8; i++) begin
      global_highpass_setting_i <= i[0];
      wr(8'h60, 4'h1, {29'h0, i[2:0]});
      repeat (3) @(posedge clk_i);
      chk(ch3_highpass_en_o, i[0] & !i[2], "hp");
    end
    $display("test setup done");
    rnd = 1'b1;
    repeat (80) begin
      lf = nxt(lf);
      i = 6'h13 + lf % 11;
      if (lf[4]) wr({i[5:0], lf[15:14]}, lf[11:8], {lf, nxt(lf)});
      else rd({i[5:0], lf[1:0]});
    end
    rnd = 1'b0;
    $display("test random done");
    @(posedge clk_i) rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    sweep();
    $display("test rerun reset done");
    results();
  end
endmodule // tb
